// file: fsq_defs.vh
`ifndef FSQ_DEFS_VH
`define FSQ_DEFS_VH

// ****************************************
// Instruction opcodes
// ****************************************
`define FSQ_OP_QUAD_OUT     8'h6B
`define FSQ_OP_DUAL_IO      8'hBB
`define FSQ_OP_QUAD_IO      8'hEB
`define FSQ_OP_WRAP_SET     8'h77
`define FSQ_OP_PAGE_PROG    8'h02

// ****************************************
// Dummy clocks before data output
// ****************************************
`define FSQ_DUMMY_QUAD_OUT  4'h8
`define FSQ_DUMMY_DUAL_IO   4'h4
`define FSQ_DUMMY_QUAD_IO   4'h4

// ****************************************
// Wrap setup byte fields and reset values
// ****************************************
`define FSQ_WRAP_DIS_POS    4
`define FSQ_WRAP_LEN_HI     6
`define FSQ_WRAP_LEN_LO     5
`define FSQ_WRAP_DIS_RST    1'b1
`define FSQ_WRAP_LEN_RST    2'h0
`define FSQ_WRAP_BASE_LEN   8'h08

// ****************************************
// Pin synchroniser reset value {cs_n, sclk, io[3:0]}
// ****************************************
`define FSQ_PIN_RST         6'h20

// ****************************************
// Program cycle timing
// ****************************************
`define FSQ_CLK_MHZ         10
`define FSQ_TPP_US          400
`define FSQ_TPP_CYCLES      (`FSQ_TPP_US * `FSQ_CLK_MHZ)

// ****************************************
// Write path buffering
// ****************************************
`define FSQ_FIFO_DEPTH      4
`define FSQ_FIFO_WIDTH      32

`endif

// file: fsq_fifo.v
`timescale 1ns/1ps
`include "fsq_defs.vh"

module fsq_fifo #(
	parameter WIDTH = `FSQ_FIFO_WIDTH,
	parameter DEPTH = `FSQ_FIFO_DEPTH
)(
	// Clock and reset
	input  wire             clk,
	input  wire             reset,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;

	wire do_push = in_valid & in_ready;
	wire do_pop  = out_valid & out_ready;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];

	// ****************************************
	// Storage has no reset; the count guards it
	// ****************************************
	always @(posedge clk)
	begin
		if (do_push)
			mem[wr_ptr] <= in_data;
	end

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (do_push & ~do_pop)
				count <= count + 1'b1;
			else if (do_pop & ~do_push)
				count <= count - 1'b1;
		end
	end
endmodule

// file: fsq_flash_seq.v
// Overview of operation
// - Quad output read accepted only with quad lane enable set; data on four lanes.
// - Quad output read: opcode, 24-bit address, eight dummy clocks, then data.
// - Dual I/O read takes address two bits per clock, returns data on two lanes.
// - Quad I/O read moves four bits per clock; four dummy clocks before data.
// - Quad I/O read accepted only while quad lane enable is set.
// - Wrap setup: opcode, 24 dummy bits, wrap byte; top bit and low nibble ignored.
// - Wrap disable 0 enables wrap; length codes select 8, 16, 32, 64 bytes.
// - Wrapped quad I/O read loops inside its aligned section until chip select rises.
// - Stored wrap setting applies to all later quad I/O reads until rewritten.
// - Wrap disable resets to 1 on power-on, software or hardware reset.
// - Page program needs write enable latch set; opcode, address, data on one lane.
// - Program loads 1 to 256 bytes; column wraps within page, later bytes overwrite.
// - Program runs only if chip select rises right after a whole byte.
// - Self-timed program cycle of tpp with busy set, then busy clears.
// - Write enable latch clears when the program cycle finishes.
// - Program to a protected page is not performed.
// - Read address advances after every output byte, streaming until chip select rises.
// - Reads arriving while busy are ignored without disturbing the running cycle.
`timescale 1ns/1ps
`include "fsq_defs.vh"

module fsq_flash_seq #(
	parameter [15:0] TPP_CYCLES = `FSQ_TPP_CYCLES,
	parameter        FIFO_DEPTH = `FSQ_FIFO_DEPTH
)(
	// Clock and reset
	input  wire        CLK,
	input  wire        RESET,
	input  wire        SOFT_RESET,
	// Serial pins
	input  wire        SPI_CS_N,
	input  wire        SPI_SCLK,
	input  wire [3:0]  SPI_IO_IN,
	output reg  [3:0]  SPI_IO_OUT,
	output reg  [3:0]  SPI_IO_OE_N,
	// Status and control bits
	input  wire        QUAD_LANE_ENABLE_BIT,
	input  wire        WEL_SET,
	input  wire        WEL_CLEAR,
	output reg         WRITE_ENABLE_LATCH,
	output reg         BUSY,
	output reg         WRAP_DISABLE_BIT,
	output reg  [1:0]  WRAP_LENGTH_FIELD,
	// Protection lookup
	output reg  [15:0] PROG_PAGE_ADDR,
	input  wire        PAGE_PROTECT_HIT,
	// Array read port
	output reg  [23:0] MEM_RD_ADDR,
	input  wire [7:0]  MEM_RD_DATA,
	// Array write port
	output wire        MEM_WR_VALID,
	input  wire        MEM_WR_READY,
	output wire [23:0] MEM_WR_ADDR,
	output wire [7:0]  MEM_WR_DATA
);
	// ****************************************
	// States
	// ****************************************
	localparam [3:0] S_IDLE   = 4'h0;
	localparam [3:0] S_CMD    = 4'h1;
	localparam [3:0] S_ADDR   = 4'h2;
	localparam [3:0] S_DUMMY  = 4'h3;
	localparam [3:0] S_DATA   = 4'h4;
	localparam [3:0] S_WRAPB  = 4'h5;
	localparam [3:0] S_PROG   = 4'h6;
	localparam [3:0] S_IGNORE = 4'h7;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function [23:0] shift_in;
		input [23:0] sr;
		input [2:0]  w;
		input [3:0]  v;
		begin
			case (w)
				3'h1:    shift_in = {sr[22:0], v[0]};
				3'h2:    shift_in = {sr[21:0], v[1:0]};
				default: shift_in = {sr[19:0], v[3:0]};
			endcase
		end
	endfunction

	function [4:0] addr_clocks;
		input [2:0] w;
		begin
			case (w)
				3'h1:    addr_clocks = 5'h18;
				3'h2:    addr_clocks = 5'h0C;
				default: addr_clocks = 5'h06;
			endcase
		end
	endfunction

	function [23:0] next_read_addr;
		input [23:0] a;
		input        wrap_on;
		input [1:0]  len;
		reg   [7:0]  m;
		reg   [7:0]  inc;
		begin
			m   = (`FSQ_WRAP_BASE_LEN << len) - 8'h01;
			inc = a[7:0] + 8'h01;
			if (wrap_on)
				next_read_addr = {a[23:8], (a[7:0] & ~m) | (inc & m)};
			else
				next_read_addr = a + 24'h00_0001;
		end
	endfunction

	// ****************************************
	// Pin synchronisers, three stages and agreement filter
	// ****************************************
	wire [5:0] pin_raw = {SPI_CS_N, SPI_SCLK, SPI_IO_IN};
	reg  [5:0] sync1;
	reg  [5:0] sync2;
	reg  [5:0] sync3;
	reg  [5:0] pin_f;
	reg  [5:0] pin_d;

	// Reset pattern matches the idle pin levels so no false edge follows reset
	localparam [5:0] PIN_RST = `FSQ_PIN_RST;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1)
		begin : g_sync
			always @(posedge CLK or posedge RESET)
			begin
				if (RESET)
				begin
					sync1[gi] <= PIN_RST[gi];
					sync2[gi] <= PIN_RST[gi];
					sync3[gi] <= PIN_RST[gi];
					pin_f[gi] <= PIN_RST[gi];
					pin_d[gi] <= PIN_RST[gi];
				end
				else
				begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi])
						pin_f[gi] <= sync3[gi];
					pin_d[gi] <= pin_f[gi];
				end
			end
		end
	endgenerate

	wire       cs_n      = pin_f[5];
	wire [3:0] io        = pin_f[3:0];
	wire       sclk_rise = pin_f[4] & ~pin_d[4] & ~cs_n;
	wire       sclk_fall = ~pin_f[4] & pin_d[4] & ~cs_n;
	wire       cs_rise   = cs_n & ~pin_d[5];

	// ****************************************
	// Instruction state
	// ****************************************
	reg  [3:0]  state;
	reg  [7:0]  cmd;
	reg  [7:0]  cmd_sr;
	reg  [4:0]  cnt;
	reg  [2:0]  w;
	reg  [2:0]  dw;
	reg  [3:0]  dmy;
	reg  [23:0] addr_sr;
	reg  [7:0]  mem_q;
	reg  [7:0]  out_sr;
	reg  [3:0]  bits_left;
	reg  [7:0]  byte_sr;
	reg  [2:0]  bitc;
	reg         byte_seen;
	reg  [7:0]  pp_col;
	reg  [255:0] loaded;
	reg  [7:0]  page_mem [0:255];

	// Program engine state
	reg  [15:0] timer;
	reg  [7:0]  drain_idx;
	reg         draining;

	wire [23:0] addr_new   = shift_in(addr_sr, w, io);
	wire [7:0]  op_new     = {cmd_sr[6:0], io[0]};
	wire [7:0]  byte_new   = {byte_sr[6:0], io[0]};
	wire [7:0]  byte_now   = (bits_left == 4'h0) ? mem_q : out_sr;
	wire        wrap_on    = (cmd == `FSQ_OP_QUAD_IO) & ~WRAP_DISABLE_BIT;
	wire [7:0]  wrap_byte  = addr_new[7:0];
	wire        prog_byte  = (state == S_PROG) & sclk_rise & (bitc == 3'h7);
	wire        prog_start = cs_rise & (state == S_PROG) & (bitc == 3'h0) & byte_seen
		& ~PAGE_PROTECT_HIT & ~BUSY;
	wire        fifo_in_valid;
	wire        fifo_in_ready;
	wire        prog_done  = BUSY & (timer == 16'h0000) & ~draining & ~MEM_WR_VALID;

	// ****************************************
	// Page buffer, column wraps inside the page
	// ****************************************
	always @(posedge CLK)
	begin
		if (prog_byte)
			page_mem[pp_col] <= byte_new;
	end

	// ****************************************
	// Instruction sequencer
	// ****************************************
	always @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state             <= S_IDLE;
			cmd               <= 8'h00;
			cmd_sr            <= 8'h00;
			cnt               <= 5'h00;
			w                 <= 3'h1;
			dw                <= 3'h4;
			dmy               <= 4'h0;
			addr_sr           <= 24'h00_0000;
			mem_q             <= 8'h00;
			out_sr            <= 8'h00;
			bits_left         <= 4'h0;
			byte_sr           <= 8'h00;
			bitc              <= 3'h0;
			byte_seen         <= 1'b0;
			pp_col            <= 8'h00;
			loaded            <= {256{1'b0}};
			PROG_PAGE_ADDR    <= 16'h0000;
			MEM_RD_ADDR       <= 24'h00_0000;
			SPI_IO_OUT        <= 4'h0;
			SPI_IO_OE_N       <= 4'hF;
			WRAP_DISABLE_BIT  <= `FSQ_WRAP_DIS_RST;
			WRAP_LENGTH_FIELD <= `FSQ_WRAP_LEN_RST;
		end
		else
		begin
			mem_q <= MEM_RD_DATA;
			if (cs_n)
			begin
				// Any unfinished instruction simply evaporates here
				state       <= S_IDLE;
				SPI_IO_OE_N <= 4'hF;
			end
			else
			begin
				case (state)
					S_IDLE:
					begin
						state <= S_CMD;
						cnt   <= 5'h00;
					end
					S_CMD:
					if (sclk_rise)
					begin
						cmd_sr <= op_new;
						cnt    <= cnt + 5'h01;
						if (cnt == 5'h07)
						begin
							cmd     <= op_new;
							cnt     <= 5'h00;
							addr_sr <= 24'h00_0000;
							if (BUSY)
								state <= S_IGNORE;
							else
							case (op_new)
								`FSQ_OP_QUAD_OUT:
								begin
									state <= QUAD_LANE_ENABLE_BIT ? S_ADDR : S_IGNORE;
									w     <= 3'h1;
									dw    <= 3'h4;
									dmy   <= `FSQ_DUMMY_QUAD_OUT;
								end
								`FSQ_OP_DUAL_IO:
								begin
									state <= S_ADDR;
									w     <= 3'h2;
									dw    <= 3'h2;
									dmy   <= `FSQ_DUMMY_DUAL_IO;
								end
								`FSQ_OP_QUAD_IO:
								begin
									state <= QUAD_LANE_ENABLE_BIT ? S_ADDR : S_IGNORE;
									w     <= 3'h4;
									dw    <= 3'h4;
									dmy   <= `FSQ_DUMMY_QUAD_IO;
								end
								`FSQ_OP_WRAP_SET:
								begin
									state <= S_ADDR;
									w     <= 3'h4;
								end
								`FSQ_OP_PAGE_PROG:
								begin
									state <= WRITE_ENABLE_LATCH ? S_ADDR : S_IGNORE;
									w     <= 3'h1;
								end
								default:
									state <= S_IGNORE;
							endcase
						end
					end
					S_ADDR:
					if (sclk_rise)
					begin
						addr_sr <= addr_new;
						cnt     <= cnt + 5'h01;
						if (cnt == addr_clocks(w) - 5'h01)
						begin
							cnt <= 5'h00;
							if (cmd == `FSQ_OP_WRAP_SET)
								state <= S_WRAPB;
							else if (cmd == `FSQ_OP_PAGE_PROG)
							begin
								state          <= S_PROG;
								pp_col         <= addr_new[7:0];
								PROG_PAGE_ADDR <= addr_new[23:8];
								bitc           <= 3'h0;
								byte_seen      <= 1'b0;
								loaded         <= {256{1'b0}};
							end
							else
							begin
								state       <= S_DUMMY;
								MEM_RD_ADDR <= addr_new;
							end
						end
					end
					S_DUMMY:
					if (sclk_rise)
					begin
						// Lane values here are not used
						cnt <= cnt + 5'h01;
						if (cnt == {1'b0, dmy} - 5'h01)
						begin
							state     <= S_DATA;
							bits_left <= 4'h0;
						end
					end
					S_DATA:
					if (sclk_fall)
					begin
						SPI_IO_OE_N <= (dw == 3'h2) ? 4'hC : 4'h0;
						if (dw == 3'h2)
						begin
							SPI_IO_OUT <= {2'h0, byte_now[7:6]};
							out_sr     <= {byte_now[5:0], 2'h0};
						end
						else
						begin
							SPI_IO_OUT <= byte_now[7:4];
							out_sr     <= {byte_now[3:0], 4'h0};
						end
						bits_left <= ((bits_left == 4'h0) ? 4'h8 : bits_left) - {1'b0, dw};
						// Fetch for the next byte starts as this one begins to leave
						if (bits_left == 4'h0)
							MEM_RD_ADDR <= next_read_addr(MEM_RD_ADDR, wrap_on, WRAP_LENGTH_FIELD);
					end
					S_WRAPB:
					if (sclk_rise)
					begin
						addr_sr <= addr_new;
						cnt     <= cnt + 5'h01;
						if (cnt == 5'h01)
						begin
							state             <= S_IGNORE;
							WRAP_DISABLE_BIT  <= wrap_byte[`FSQ_WRAP_DIS_POS];
							WRAP_LENGTH_FIELD <= wrap_byte[`FSQ_WRAP_LEN_HI:`FSQ_WRAP_LEN_LO];
						end
					end
					S_PROG:
					if (sclk_rise)
					begin
						byte_sr <= byte_new;
						bitc    <= bitc + 3'h1;
						if (bitc == 3'h7)
						begin
							loaded[pp_col] <= 1'b1;
							pp_col         <= pp_col + 8'h01;
							byte_seen      <= 1'b1;
						end
					end
					S_IGNORE:
						state <= S_IGNORE;
					default:
						state <= S_IGNORE;
				endcase
			end
			if (SOFT_RESET)
			begin
				WRAP_DISABLE_BIT  <= `FSQ_WRAP_DIS_RST;
				WRAP_LENGTH_FIELD <= `FSQ_WRAP_LEN_RST;
			end
		end
	end

	// ****************************************
	// Self-timed program cycle
	// ****************************************
	// Busy lasts at least tpp; a stalled array write port stretches it
	assign fifo_in_valid = BUSY & draining & loaded[drain_idx];

	always @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			BUSY               <= 1'b0;
			timer              <= 16'h0000;
			drain_idx          <= 8'h00;
			draining           <= 1'b0;
			WRITE_ENABLE_LATCH <= 1'b0;
		end
		else
		begin
			if (prog_start)
			begin
				BUSY      <= 1'b1;
				timer     <= TPP_CYCLES;
				drain_idx <= 8'h00;
				draining  <= 1'b1;
			end
			else if (BUSY)
			begin
				if (timer != 16'h0000)
					timer <= timer - 16'h0001;
				if (draining & (~loaded[drain_idx] | fifo_in_ready))
				begin
					drain_idx <= drain_idx + 8'h01;
					if (drain_idx == 8'hFF)
						draining <= 1'b0;
				end
				if (prog_done)
					BUSY <= 1'b0;
			end
			if (WEL_SET)
				WRITE_ENABLE_LATCH <= 1'b1;
			else if (WEL_CLEAR | SOFT_RESET | prog_done)
				WRITE_ENABLE_LATCH <= 1'b0;
		end
	end

	// ****************************************
	// Write buffer toward the array
	// ****************************************
	fsq_fifo #(
		.WIDTH (`FSQ_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk       (CLK),
		.reset     (RESET),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   ({PROG_PAGE_ADDR, drain_idx, page_mem[drain_idx]}),
		.out_valid (MEM_WR_VALID),
		.out_ready (MEM_WR_READY),
		.out_data  ({MEM_WR_ADDR, MEM_WR_DATA})
	);
endmodule

// file: fsq_host_model.sv
`timescale 1ns/1ps
// ****************************************
// Serial host model, mode 0, link clock still between frames
// ****************************************
module fsq_host_model (
	// Pins towards the device
	output logic       cs_n,
	output logic       sclk,
	output logic [3:0] io_drv,
	// Resolved lane levels
	input  wire  [3:0] io_lvl
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io_drv = 4'h0;
	end

	task automatic frame(input bit on);
		if (on)
		begin
			cs_n = 1'b0;
			#400;
		end
		else
		begin
			#400;
			cs_n = 1'b1;
			#1600;
		end
	endtask

	// Lanes change at the falling edge; sampling late covers the device's sync delay
	task automatic shift(input int n, input int w, input logic [63:0] d, output logic [63:0] q);
		q = 64'h0;
		for (int i = 0; i < n; i++)
		begin
			io_drv = 4'(d[63:60] >> (4 - w));
			d = d << w;
			#400 sclk = 1'b1;
			#400 q = (q << w) | 64'(io_lvl & 4'((1 << w) - 1));
			sclk = 1'b0;
		end
	endtask
endmodule

// file: fsq_properties.sv
`timescale 1ns/1ps
`include "fsq_defs.vh"
// ****************************************
// Port checker
// ****************************************
module fsq_checker #(
	parameter [15:0] TPP_CYCLES = `FSQ_TPP_CYCLES
)(
	// Clock and reset
	input wire        CLK,
	input wire        RESET,
	input wire        SOFT_RESET,
	// Pins and status
	input wire        SPI_CS_N,
	input wire [3:0]  SPI_IO_OE_N,
	input wire        QUAD_LANE_ENABLE_BIT,
	input wire        WEL_SET,
	input wire        WRITE_ENABLE_LATCH,
	input wire        BUSY,
	input wire        WRAP_DISABLE_BIT,
	input wire        PAGE_PROTECT_HIT,
	input wire [15:0] PROG_PAGE_ADDR,
	// Write port
	input wire        MEM_WR_VALID,
	input wire        MEM_WR_READY,
	input wire [23:0] MEM_WR_ADDR,
	input wire [7:0]  MEM_WR_DATA
);
	reg [15:0] busy_len;

	always @(posedge CLK or posedge RESET)
		if (RESET)
			busy_len <= 16'h0000;
		else if (BUSY)
			busy_len <= busy_len + 16'h0001;
		else
			busy_len <= 16'h0000;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	property p_lanes; SPI_IO_OE_N inside {4'hF, 4'hC, 4'h0}; endproperty
	a_lanes: assert property (p_lanes) else $error("lane enables out of pattern");
	property p_quad_qe; SPI_IO_OE_N == 4'h0 |-> QUAD_LANE_ENABLE_BIT; endproperty
	a_quad_qe: assert property (p_quad_qe) else $error("quad drive without enable");
	property p_oe_release; $rose(SPI_CS_N) |-> ##[1:8] SPI_IO_OE_N == 4'hF; endproperty
	a_oe_release: assert property (p_oe_release) else $error("lanes kept after deselect");
	property p_wrap_rst; $fell(RESET) |-> WRAP_DISABLE_BIT; endproperty
	a_wrap_rst: assert property (p_wrap_rst) else $error("wrap on after reset");
	property p_soft; SOFT_RESET |=> WRAP_DISABLE_BIT; endproperty
	a_soft: assert property (p_soft) else $error("wrap on after soft reset");
	property p_wel_done; $fell(BUSY) && !$past(WEL_SET) |-> !WRITE_ENABLE_LATCH; endproperty
	a_wel_done: assert property (p_wel_done) else $error("latch kept after program");
	property p_busy_wel; $rose(BUSY) |-> $past(WRITE_ENABLE_LATCH); endproperty
	a_busy_wel: assert property (p_busy_wel) else $error("program without latch");
	property p_busy_prot; $rose(BUSY) |-> !$past(PAGE_PROTECT_HIT); endproperty
	a_busy_prot: assert property (p_busy_prot) else $error("protected page programmed");
	property p_tpp; $fell(BUSY) |-> busy_len >= TPP_CYCLES; endproperty
	a_tpp: assert property (p_tpp) else $error("program cycle too short");
	property p_read_busy; BUSY |-> SPI_IO_OE_N == 4'hF; endproperty
	a_read_busy: assert property (p_read_busy) else $error("read served while busy");
	property p_wr_hold;
		MEM_WR_VALID && !MEM_WR_READY |=> MEM_WR_VALID && $stable(MEM_WR_ADDR) && $stable(MEM_WR_DATA);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write dropped while stalled");
	property p_wr_page; MEM_WR_VALID |-> BUSY && MEM_WR_ADDR[23:8] == PROG_PAGE_ADDR; endproperty
	a_wr_page: assert property (p_wr_page) else $error("write outside page");

	c_prog: cover property ($rose(BUSY));
	c_quad: cover property (SPI_IO_OE_N == 4'h0);
	c_dual: cover property (SPI_IO_OE_N == 4'hC);
	c_wrap: cover property ($fell(WRAP_DISABLE_BIT));
endmodule

bind fsq_flash_seq fsq_checker #(.TPP_CYCLES(TPP_CYCLES)) u_fsq_checker (.CLK, .RESET, .SOFT_RESET, .SPI_CS_N,
	.SPI_IO_OE_N, .QUAD_LANE_ENABLE_BIT, .WEL_SET, .WRITE_ENABLE_LATCH, .BUSY, .WRAP_DISABLE_BIT,
	.PAGE_PROTECT_HIT, .PROG_PAGE_ADDR, .MEM_WR_VALID, .MEM_WR_READY, .MEM_WR_ADDR, .MEM_WR_DATA);

// file: test_serial_flash_fast_read_program.sv
`timescale 1ns/1ps
`include "fsq_defs.vh"
// ****************************************
// Bench top
// ****************************************
module test_serial_flash_fast_read_program;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        soft_reset = 1'b0;
	logic        qe = 1'b1;
	logic        wel_set = 1'b0;
	logic        wel_clr = 1'b0;
	logic        prot = 1'b0;
	logic        stall = 1'b0;
	int          drive_cnt = 0;
	logic        wr_ready = 1'b0;
	logic [7:0]  rd_data = 8'h00;
	logic        cs_n, sclk, write_enable_latch, busy, wdis, wr_valid;
	logic [3:0]  io_drv, io_out, io_oe_n, io_lvl;
	logic [1:0]  wlen;
	logic [15:0] pg;
	logic [23:0] rd_addr, wr_addr;
	logic [7:0]  wr_data;
	logic [31:0] wq[$];
	int          errors = 0;
	int          total_checks = 0;

	// No pull on the lanes: an undriven lane shows the host's changing pattern
	assign io_lvl = (io_out & ~io_oe_n) | (io_drv & io_oe_n);
	always #50 clk = ~clk;

	fsq_flash_seq #(.TPP_CYCLES(16'd20)) u_fsq_flash_seq (.CLK(clk), .RESET(reset), .SOFT_RESET(soft_reset),
		.SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_IO_IN(io_lvl), .SPI_IO_OUT(io_out), .SPI_IO_OE_N(io_oe_n),
		.QUAD_LANE_ENABLE_BIT(qe), .WEL_SET(wel_set), .WEL_CLEAR(wel_clr), .WRITE_ENABLE_LATCH(write_enable_latch),
		.BUSY(busy), .WRAP_DISABLE_BIT(wdis), .WRAP_LENGTH_FIELD(wlen), .PROG_PAGE_ADDR(pg),
		.PAGE_PROTECT_HIT(prot), .MEM_RD_ADDR(rd_addr), .MEM_RD_DATA(rd_data), .MEM_WR_VALID(wr_valid),
		.MEM_WR_READY(wr_ready), .MEM_WR_ADDR(wr_addr), .MEM_WR_DATA(wr_data));
	fsq_host_model u_fsq_host_model (.cs_n(cs_n), .sclk(sclk), .io_drv(io_drv), .io_lvl(io_lvl));

	function automatic [7:0] mb(input [23:0] a);
		mb = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
	endfunction

	function automatic [23:0] wa(input [23:0] a, input int j, input int n);
		wa = (a & ~24'(n - 1)) | ((a + 24'(j)) & 24'(n - 1));
	endfunction

	function automatic [63:0] rnd();
		rnd = {$urandom, $urandom};
	endfunction

	// Array model answers one cycle after the address
	always @(posedge clk)
	begin
		rd_data <= mb(rd_addr);
		if (wr_valid && wr_ready)
			wq.push_back({wr_addr, wr_data});
		if (io_oe_n !== 4'hF)
			drive_cnt <= drive_cnt + 1;
	end

	always @(negedge clk)
		wr_ready <= !stall && 1'($urandom);

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask

	// Odd offset keeps the link clock out of step with the system clock
	task automatic fr(input bit on);
		if (on)
			#37;
		u_fsq_host_model.frame(on);
		if (!on)
			cyc(1);
	endtask

	task automatic sh(input int n, input int w, input logic [63:0] d, output logic [63:0] q);
		u_fsq_host_model.shift(n, w, d, q);
	endtask

	task automatic hdr(input [7:0] op, input [23:0] a);
		logic [63:0] q;
		int          w;
		w = (op == `FSQ_OP_QUAD_OUT) ? 1 : (op == `FSQ_OP_DUAL_IO) ? 2 : 4;
		fr(1);
		sh(8, 1, {op, 56'h0}, q);
		sh(24 / w, w, {a, 40'h0}, q);
		sh((op == `FSQ_OP_QUAD_OUT) ? 8 : 4, w, rnd(), q);
	endtask

	task automatic wrap_set(input [7:0] wb, input int nib);
		logic [63:0] q;
		fr(1);
		sh(8, 1, {`FSQ_OP_WRAP_SET, 56'h0}, q);
		// Zero filler makes an early update on a cut frame visible
		sh(6, 4, (nib < 2) ? 64'h0 : rnd(), q);
		sh(nib, 4, {wb, 56'h0}, q);
		fr(0);
		cyc(8);
	endtask

	task automatic prog(input [23:0] a, input int nbits, input [63:0] d);
		logic [63:0] q;
		fr(1);
		sh(8, 1, {`FSQ_OP_PAGE_PROG, 56'h0}, q);
		sh(24, 1, {a, 40'h0}, q);
		sh(nbits, 1, d, q);
		fr(0);
		cyc(10);
	endtask

	task automatic wait_busy(input logic lvl);
		for (int k = 0; k < 5000 && busy !== lvl; k++)
			@(negedge clk);
		if (busy !== lvl)
		begin
			errors++;
			$display("mismatch busy_wait expected %b seen %b", lvl, busy);
			print_verdict();
		end
	endtask

	initial
	begin
		logic [7:0]  ops [3];
		logic [63:0] q, e, d;
		logic [7:0]  wb;
		logic [23:0] a;
		int          w, n, col;
		void'($urandom(32'h4f040805));
		ops = '{`FSQ_OP_QUAD_OUT, `FSQ_OP_DUAL_IO, `FSQ_OP_QUAD_IO};
		cyc(8);
		reset = 1'b0;
		cyc(6);
		chk("wrap_disable_reset", 1'b1, wdis);
		for (int i = 0; i < 3; i++)
		begin
			a = 24'($urandom);
			w = (i == 1) ? 2 : 4;
			hdr(ops[i], a);
			sh(32 / w, w, rnd(), q);
			fr(0);
			e = 64'h0;
			for (int j = 0; j < 4; j++)
				e = {e[55:0], mb(a + 24'(j))};
			chk("read_data", e, q[31:0]);
		end
		qe = 1'b0;
		n = drive_cnt;
		hdr(`FSQ_OP_QUAD_OUT, 24'h00_0100);
		sh(8, 4, rnd(), q);
		fr(0);
		hdr(`FSQ_OP_QUAD_IO, 24'h00_0100);
		sh(8, 4, rnd(), q);
		fr(0);
		// An opcode that nothing decodes stays silent too
		hdr(8'hA5, 24'h00_0100);
		sh(8, 4, rnd(), q);
		fr(0);
		chk("refused_quad_drive", n, drive_cnt);
		qe = 1'b1;
		for (int c = 0; c < 5; c++)
		begin
			wb = {1'($urandom), 2'(c), c == 4, 4'($urandom)};
			wrap_set(wb, 2);
			chk("wrap_disable", c == 4, wdis);
			chk("wrap_length", wb[6:5], wlen);
			a = 24'($urandom);
			n = (c < 4) ? (8 << c) + 4 : 12;
			hdr(`FSQ_OP_QUAD_IO, a);
			for (int j = 0; j < n; j++)
			begin
				sh(2, 4, rnd(), q);
				e = (c < 4) ? mb(wa(a, j, 8 << c)) : mb(a + 24'(j));
				chk("wrap_read", e, q[7:0]);
			end
			fr(0);
		end
		wrap_set(8'h00, 1);
		chk("wrap_truncated", 1'b1, wdis);
		wrap_set(8'h20, 2);
		pulse(soft_reset);
		chk("wrap_soft_reset", 1'b1, wdis);
		chk("wrap_length_soft_reset", 2'h0, wlen);
		d = rnd();
		prog(24'h00_1200, 24, d);
		chk("busy_no_latch", 1'b0, busy);
		pulse(wel_set);
		pulse(wel_clr);
		chk("latch_cleared", 1'b0, write_enable_latch);
		pulse(wel_set);
		pulse(soft_reset);
		chk("latch_soft_reset", 1'b0, write_enable_latch);
		pulse(wel_set);
		prot = 1'b1;
		prog(24'h00_1200, 24, d);
		chk("busy_protected", 1'b0, busy);
		prot = 1'b0;
		prog(24'h00_1200, 11, d);
		chk("busy_partial_byte", 1'b0, busy);
		chk("latch_kept", 1'b1, write_enable_latch);
		// Drain held off so the four-word buffer fills and refuses
		stall = 1'b1;
		a = {16'($urandom), 8'hFC};
		prog(a, 64, d);
		wait_busy(1'b1);
		n = drive_cnt;
		hdr(`FSQ_OP_QUAD_OUT, a);
		sh(8, 4, rnd(), q);
		fr(0);
		chk("read_while_busy", n, drive_cnt);
		chk("busy_after_read", 1'b1, busy);
		stall = 1'b0;
		wait_busy(1'b0);
		chk("latch_after_program", 1'b0, write_enable_latch);
		chk("write_count", 8, wq.size());
		for (int k = 0; k < 8; k++)
		begin
			col = (k < 4) ? k : 248 + k;
			chk("write_word", {a[23:8], 8'(col), d[63 - 8 * ((col - 252) & 255) -: 8]}, wq[k]);
		end
		wrap_set(8'h40, 2);
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		cyc(6);
		chk("wrap_hw_reset", 1'b1, wdis);
		chk("wrap_length_hw_reset", 2'h0, wlen);
		print_verdict();
	end
endmodule
